// ===== rtl/dmsh_pkg.sv
package dmsh_pkg;
    // Clock rates and serial clock limits.
    localparam int REF_MHZ       = 100;
    localparam int SCLK_MAX_MHZ  = 40;
    localparam int SCLK_MIN_HALF = (REF_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
    localparam int SYNC_LAG      = 2;
    localparam int HALF_FLOOR    = SCLK_MIN_HALF + SYNC_LAG;
    localparam logic [4:0] FRAME_BITS = 5'h18;

    // Own register map, byte addresses.
    localparam logic [5:0] REG_CTRL   = 6'h00;
    localparam logic [5:0] REG_CADDR  = 6'h04;
    localparam logic [5:0] REG_CDATA  = 6'h08;
    localparam logic [5:0] REG_RUNCMD = 6'h0c;
    localparam logic [5:0] REG_STAT   = 6'h10;
    localparam logic [5:0] REG_SAMPLE = 6'h14;
    localparam logic [5:0] REG_CRD    = 6'h18;
    localparam logic [5:0] REG_CHAN0  = 6'h20;

    // Control register fields.
    localparam int CB_GO_CFG = 0;
    localparam int CB_RD     = 1;
    localparam int CB_GO_RUN = 2;
    localparam int CB_AUTO   = 3;
    localparam int CB_EESEL  = 4;
    localparam int CB_PAR    = 5;
    localparam int CB_STAT   = 6;
    localparam int CB_MODE   = 7;

    // Status register fields.
    localparam int SB_BUSY   = 0;
    localparam int SB_READY  = 1;
    localparam int SB_CDONE  = 2;
    localparam int SB_NEW    = 3;
    localparam int SB_PERR   = 4;
    localparam int SB_RANGE  = 5;

    // Reset values.
    localparam logic [13:0] CADDR_RST  = 14'h0000;
    localparam logic [7:0]  CDATA_RST  = 8'h00;
    localparam logic [7:0]  CTRL_RST   = 8'h00;

    // Device side constants.
    localparam logic [13:0] DEV_MODE_ADDR  = 14'h0004;
    localparam logic [7:0]  DEV_MODE_ADDR8 = 8'h04;
    localparam logic [7:0]  DEV_DUMMY_ADDR = 8'h00;
    localparam logic        DEV_RD         = 1'b1;
    localparam logic        MODE_RUN       = 1'b1;

    typedef struct packed {
        logic       parity;
        logic [1:0] source_channel_code;
        logic       new_flag;
        logic       over_range_sticky;
        logic       over_range_live;
        logic       under_range_sticky;
        logic       under_range_live;
    } dmsh_info_t;

    typedef struct packed {
        dmsh_info_t info;
        logic [7:0] hi;
        logic [7:0] lo;
    } dmsh_word_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_SETUP = 5'h02,
        ST_SHIFT = 5'h04,
        ST_HOLD  = 5'h08,
        ST_GAP   = 5'h10
    } dmsh_state_t;
endpackage

// ===== rtl/dmsh_host_ctrl.sv
`timescale 1ns/100ps
// Overview of operation
// - Host is the only master and keeps serial clock at or below 40 MHz.
// - Host raises the ready/select pin only while in configure mode.
// - Configure command word: direction bit, 14 address bits, ignored last bit.
// - One data byte follows the command, written or read back.
// - Wide registers are written byte by byte from the lowest address upward.
// - User storage is moved in 8-byte blocks using consecutive addresses.
// - Latched range flags clear only when zero is written to channel status.
// - Run-mode input carries an 8-bit command address then a data byte.
// - Parity is not trusted while range status reporting is enabled.
// - In run mode, select stays low until the ready pin has cleared; configure frames do not wait.
// - Writing zero to mode bit 0 in run mode returns to configure mode.
// - Idle run-mode frames send the dummy register address 00h.
module dmsh_host_ctrl
    import dmsh_pkg::*;
#(
    parameter int HALF_CYC = 4,
    parameter int CS_GAP   = 2
) (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // Software register port.
    input  wire logic [5:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Serial link to the converter.
    output logic             spi_cs_n,
    output logic             spi_sclk,
    output logic             spi_mosi,
    input  wire logic        spi_miso,
    // Shared ready / EEPROM select pin.
    input  wire logic        ready_or_eeprom_select_pin_in,
    output logic             ready_or_eeprom_select_pin_out,
    output logic             ready_or_eeprom_select_pin_oe
);

    localparam int HALF_EFF = (HALF_CYC < HALF_FLOOR) ? HALF_FLOOR : HALF_CYC;
    localparam logic [7:0] HALF_LAST = 8'(HALF_EFF - 1);
    localparam logic [7:0] GAP_LAST  = 8'(CS_GAP - 1);
    function automatic logic odd_ones(input logic [23:0] w);
        odd_ones = ^w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers.
    logic [1:0] miso_sync;
    logic [1:0] rdy_sync;
    logic       miso_s;
    logic       sample_ready_strobe;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            miso_sync <= 2'h0;
            rdy_sync  <= 2'h0;
        end else begin
            miso_sync <= {miso_sync[0], spi_miso};
            rdy_sync  <= {rdy_sync[0], ready_or_eeprom_select_pin_in};
        end
    end

    assign miso_s              = miso_sync[1];
    assign sample_ready_strobe = rdy_sync[1];

    ////////////////////////////////////////////////////////////////////////////
    // Software-visible state and frame requests.
    logic [7:0]  ctrl;
    logic [13:0] caddr;
    logic [7:0]  cdata;
    logic [15:0] runcmd;
    logic        run_pending;
    logic [7:0]  crd;
    logic [5:0]  stat;
    dmsh_word_t  last_word;
    logic [15:0] chan_mem [4];
    dmsh_state_t state;
    logic        busy;
    logic        kind_run;
    logic        kind_rd;
    logic        done;
    logic [23:0] rx;
    logic [23:0] tx_frame;
    logic        go_cfg;
    logic        go_run;
    logic        ctrl_wr;
    logic        mode;
    assign busy    = (state != ST_IDLE);
    assign mode    = ctrl[CB_MODE];
    assign ctrl_wr = reg_wr && (reg_addr == REG_CTRL);

    assign go_cfg = !busy && (mode != MODE_RUN) && ctrl_wr && reg_wdata[CB_GO_CFG];
    assign go_run = !busy && (mode == MODE_RUN)
                    && ((ctrl_wr && reg_wdata[CB_GO_RUN])
                        || (ctrl[CB_AUTO] && sample_ready_strobe));

    assign tx_frame = go_run ? (run_pending ? {runcmd, 8'h00} : {DEV_DUMMY_ADDR, 16'h0000})
                             : {reg_wdata[CB_RD], caddr, 1'b0, cdata};

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl  <= CTRL_RST;
            caddr <= CADDR_RST;
            cdata <= CDATA_RST;
        end else begin
            if (ctrl_wr) begin
                ctrl <= {reg_wdata[7:3], 3'h0};
            end else if (done && !kind_rd
                         && (kind_run ? (runcmd[15:8] == DEV_MODE_ADDR8)
                                      : (caddr == DEV_MODE_ADDR))) begin
                ctrl[CB_MODE] <= kind_run ? runcmd[0] : cdata[0];
            end
            if (reg_wr && (reg_addr == REG_CADDR)) begin
                caddr <= reg_wdata[13:0];
            end else if (done && !kind_run) begin
                caddr <= caddr + 14'h0001;
            end
            if (reg_wr && (reg_addr == REG_CDATA)) begin
                cdata <= reg_wdata[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            runcmd      <= {DEV_DUMMY_ADDR, 8'h00};
            run_pending <= 1'b0;
        end else begin
            if (reg_wr && (reg_addr == REG_RUNCMD)) begin
                runcmd      <= reg_wdata[15:0];
                run_pending <= 1'b1;
            end else if (go_run) begin
                run_pending <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Received data and sticky status.
    dmsh_word_t rxw;
    logic       par_chk;
    logic [5:0] stat_set;
    logic       stat_clr;

    assign rxw      = dmsh_word_t'(rx);
    assign par_chk  = ctrl[CB_PAR] && !ctrl[CB_STAT];
    assign stat_clr = reg_wr && (reg_addr == REG_STAT);

    always_comb begin
        stat_set           = 6'h00;
        stat_set[SB_CDONE] = done && !kind_run;
        stat_set[SB_NEW]   = done && kind_run && rxw.info.new_flag;
        stat_set[SB_PERR]  = done && kind_run && par_chk && !odd_ones(rx);
        stat_set[SB_RANGE] = done && kind_run && ctrl[CB_STAT]
                             && (rxw.info.over_range_sticky || rxw.info.under_range_sticky);
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stat <= 6'h00;
        end else begin
            stat <= stat_set | (stat & ~(stat_clr ? reg_wdata[5:0] : 6'h00));
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            crd       <= 8'h00;
            last_word <= '0;
        end else if (done && kind_run) begin
            last_word <= rxw;
        end else if (done && kind_rd) begin
            crd <= rx[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 4; i++) begin
                chan_mem[i] <= 16'h0000;
            end
        end else if (done && kind_run && rxw.info.new_flag) begin
            chan_mem[rxw.info.source_channel_code] <= {rxw.hi, rxw.lo};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL:   reg_rdata <= {24'h0, ctrl};
                REG_CADDR:  reg_rdata <= {18'h0, caddr};
                REG_CDATA:  reg_rdata <= {24'h0, cdata};
                REG_RUNCMD: reg_rdata <= {15'h0, run_pending, runcmd};
                REG_STAT:   reg_rdata <= {26'h0, stat[SB_RANGE:SB_CDONE], sample_ready_strobe, busy};
                REG_SAMPLE: reg_rdata <= {8'h0, last_word};
                REG_CRD:    reg_rdata <= {24'h0, crd};
                6'h20, 6'h24, 6'h28, 6'h2c:
                    reg_rdata <= {16'h0, chan_mem[reg_addr[3:2]]};
                default:    reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared pin drive.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ready_or_eeprom_select_pin_out <= 1'b0;
            ready_or_eeprom_select_pin_oe  <= 1'b0;
        end else begin
            ready_or_eeprom_select_pin_out <= 1'b1;
            ready_or_eeprom_select_pin_oe  <= ctrl[CB_EESEL] && (mode != MODE_RUN) && !busy
                                              && !go_cfg && !go_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine.
    logic [23:0] tx;
    logic [7:0]  cnt;
    logic [4:0]  bits;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state    <= ST_IDLE;
            spi_cs_n <= 1'b1;
            spi_sclk <= 1'b0;
            spi_mosi <= 1'b0;
            tx       <= 24'h0;
            rx       <= 24'h0;
            cnt      <= 8'h00;
            bits     <= 5'h00;
            kind_run <= 1'b0;
            kind_rd  <= 1'b0;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (go_cfg || go_run) begin
                        spi_cs_n <= 1'b0;
                        spi_mosi <= tx_frame[23];
                        tx       <= tx_frame;
                        kind_run <= go_run;
                        kind_rd  <= go_cfg && (reg_wdata[CB_RD] == DEV_RD);
                        cnt      <= 8'h00;
                        state    <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == HALF_LAST) begin
                        cnt   <= 8'h00;
                        bits  <= FRAME_BITS;
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == HALF_LAST) begin
                        cnt      <= 8'h00;
                        spi_sclk <= !spi_sclk;
                        if (spi_sclk) begin
                            rx       <= {rx[22:0], miso_s};
                            tx       <= {tx[22:0], 1'b0};
                            spi_mosi <= tx[22];
                            bits     <= bits - 5'h01;
                            if (bits == 5'h01) begin
                                state <= ST_HOLD;
                            end
                        end
                    end
                end
                ST_HOLD: begin
                    if (!kind_run || !sample_ready_strobe) begin
                        spi_cs_n <= 1'b1;
                        spi_mosi <= 1'b0;
                        done     <= 1'b1;
                        cnt      <= 8'h00;
                        state    <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    cnt <= cnt + 8'h01;
                    if (cnt >= GAP_LAST) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state    <= ST_IDLE;
                    spi_cs_n <= 1'b1;
                    spi_sclk <= 1'b0;
                end
            endcase
        end
    end

endmodule

// ===== sim/dmsh_host_monitor.sv
`timescale 1ns/100ps
module dmsh_host_monitor
    import dmsh_pkg::*;
#(
    parameter int HALF_CYC = 4,
    parameter int CS_GAP   = 2
) (
    // Clock, reset and read port.
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Serial link and ready pin.
    input wire logic        spi_cs_n,
    input wire logic        spi_sclk,
    input wire logic        spi_mosi,
    input wire logic        ready_or_eeprom_select_pin_in,
    input wire logic        ready_or_eeprom_select_pin_out,
    input wire logic        ready_or_eeprom_select_pin_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////
    chk_sclk_idle: assert property (spi_cs_n |-> !spi_sclk)
        else $error("serial clock moved while deselected");
    chk_cs_gap: assert property ($rose(spi_cs_n) |-> spi_cs_n [*3])
        else $error("select gap too short");
    chk_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    chk_sel_drive: assert property (ready_or_eeprom_select_pin_oe |->
        spi_cs_n && ready_or_eeprom_select_pin_out)
        else $error("select pin driven during a frame");
    chk_mosi_hold: assert property (spi_sclk && $past(spi_sclk) |-> $stable(spi_mosi))
        else $error("data changed while clock high");
    chk_first_bit: assert property ($fell(spi_cs_n) |=> $stable(spi_mosi) [*4])
        else $error("first bit not held");
    chk_first_edge: assert property ($fell(spi_cs_n) |-> !spi_sclk [*8] ##1 spi_sclk)
        else $error("first clock edge misplaced");
    chk_half_period: assert property ($rose(spi_sclk) |-> spi_sclk [*4] ##1 !spi_sclk)
        else $error("clock high phase wrong");
    chk_ready_clear: assert property ($rose(spi_cs_n) |->
        !$past(ready_or_eeprom_select_pin_in, 3))
        else $error("select released while ready high");
    cover property ($fell(spi_cs_n));
    cover property ($rose(spi_cs_n) && $past(ready_or_eeprom_select_pin_in, 4));
    cover property ($rose(ready_or_eeprom_select_pin_oe));
endmodule
bind dmsh_host_ctrl dmsh_host_monitor #(.HALF_CYC(HALF_CYC), .CS_GAP(CS_GAP)) u_mon (.*);

// ===== sim/dmsh_dev_model.sv
`timescale 1ns/100ps
module dmsh_dev_model
    import dmsh_pkg::*;
(
    // Serial link.
    input  wire logic spi_cs_n,
    input  wire logic spi_sclk,
    input  wire logic spi_mosi,
    output logic      spi_miso,
    // Ready pin drive.
    output logic      rdy_oe,
    output logic      rdy_val
);
    logic [7:0]  mem [16384];
    logic [23:0] rx;
    logic [23:0] tx;
    logic        run;
    logic [1:0]  ch;
    int          n;
    ////////////////////////////////////////
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        {rx, tx, run, ch, rdy_val} = '0;
        n = 0;
    end
    assign rdy_oe = run;
    assign spi_miso = spi_cs_n ? ~tx[23] : tx[23];
    always @(negedge spi_cs_n) begin
        n = 0;
        tx = {1'b0, ch, 1'b1, 4'h0, 16'h1234 + 16'h1111 * ch};
        tx[23] = ~^tx[22:0];
        if (!run) tx = '0;
    end
    always @(posedge spi_sclk) begin
        if (!spi_cs_n) begin
            rx = {rx[22:0], spi_mosi};
            n = n + 1;
            if (n == 16 && rx[15] && !run) tx = {1'b0, mem[rx[14:1]], 15'h0};
        end
    end
    always @(negedge spi_sclk) begin
        if (!spi_cs_n) tx = tx << 1;
    end
    always @(posedge spi_cs_n) begin
        if (n == 24 && !run) begin
            if (!rx[23]) mem[rx[22:9]] = rx[7:0];
            if (!rx[23] && rx[22:9] == DEV_MODE_ADDR) run = rx[0];
        end else if (n == 24) begin
            mem[rx[23:16]] = rx[15:8];
            if (rx[23:16] == DEV_MODE_ADDR8) run = rx[8];
            ch = ch + 2'h1;
        end
    end
    initial begin
        forever begin
            #300;
            if (run && spi_cs_n) rdy_val = 1'b1;
            wait (!spi_cs_n);
            rdy_val = 1'b0;
        end
    end
endmodule

// ===== sim/dual_mode_spi_slave_port_test.sv
`timescale 1ns/100ps
module dual_mode_spi_slave_port_test
    import dmsh_pkg::*;
;
    typedef struct packed {
        logic        rd;
        logic [13:0] addr;
        logic [7:0]  data;
    } dmsh_row_t;
    localparam dmsh_row_t ROWS [6] = '{
        '{1'b0, 14'h0123, 8'h5a}, '{1'b0, 14'h3fff, 8'ha5}, '{1'b1, 14'h0123, 8'h5a},
        '{1'b1, 14'h3fff, 8'ha5}, '{1'b1, 14'h0456, 8'h00}, '{1'b0, 14'h0001, 8'h3c}};
    localparam logic [5:0] RST_ADDR [5] = '{REG_CTRL, REG_CADDR, REG_CDATA, REG_RUNCMD, 6'h3c};
    logic        ref_clk, arst_n, reg_wr, reg_rd, spi_cs_n, spi_sclk, spi_mosi, spi_miso;
    logic        pin, pin_out, pin_oe, dev_oe, dev_val;
    logic [5:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    int          miscompares, checked;
    ////////////////////////////////////////
    assign pin = pin_oe ? pin_out : (dev_oe & dev_val);
    dmsh_host_ctrl #(.HALF_CYC(4), .CS_GAP(2)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .ready_or_eeprom_select_pin_in(pin),
        .ready_or_eeprom_select_pin_out(pin_out), .ready_or_eeprom_select_pin_oe(pin_oe));
    dmsh_dev_model u_dev (.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .rdy_oe(dev_oe), .rdy_val(dev_val));
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask
    task automatic idle();
        v = 32'h1;
        for (int k = 0; k < 800 && v[SB_BUSY] !== 1'b0; k++) rd(REG_STAT);
        chk(v[SB_BUSY], 32'h0, "busy stuck");
    endtask
    task automatic cfg(input logic rw, input logic [13:0] a, input logic [7:0] d);
        wr(REG_CADDR, {18'h0, a});
        wr(REG_CDATA, {24'h0, d});
        wr(REG_CTRL, {30'h0, rw, 1'b1});
        idle();
    endtask
    function automatic logic [31:0] word_of(input int c);
        logic [23:0] w;
        w = {1'b0, 2'(c), 1'b1, 4'h0, 16'(16'h1234 + 16'h1111 * c)};
        w[23] = ~^w[22:0];
        return {8'h0, w};
    endfunction
    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #300000;
        miscompares++;
        $display("wrong value at %0t: watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, arst_n, miscompares, checked} = '0;
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        foreach (ROWS[i]) begin
            cfg(ROWS[i].rd, ROWS[i].addr, ROWS[i].data);
            rd(REG_CADDR);
            chk(v, {18'h0, ROWS[i].addr + 14'h1}, "address step");
            rd(REG_CRD);
            if (ROWS[i].rd) chk(v, {24'h0, ROWS[i].data}, "read byte");
            $display("row %0d done", i);
        end
        wr(REG_CTRL, 32'h1);
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b0;
        @(posedge ref_clk);
        #1 chk({spi_cs_n, spi_sclk, pin_oe}, 32'h4, "outputs in reset");
        @(posedge ref_clk);
        arst_n <= 1'b1;
        foreach (RST_ADDR[i]) begin
            rd(RST_ADDR[i]);
            chk(v, 32'h0, "reset value");
        end
        wr(REG_CTRL, 32'h10);
        repeat (3) @(posedge ref_clk);
        #1 chk({pin_oe, pin_out}, 32'h3, "select drive");
        wr(REG_CTRL, 32'h0);
        $display("reset and select tests done");
        cfg(1'b0, DEV_MODE_ADDR, 8'h01);
        rd(REG_CTRL);
        chk(v[CB_MODE], 32'h1, "mode follow");
        wr(REG_RUNCMD, 32'h3077);
        wr(REG_CTRL, 32'ha4);
        idle();
        rd(REG_SAMPLE);
        chk(v, word_of(0), "run word");
        rd(REG_STAT);
        chk(v[5:3], 32'h1, "run status");
        wr(REG_CTRL, 32'ha8);
        for (int k = 0; k < 2000 && v !== 32'h4567; k++) rd(REG_CHAN0 + 6'h0c);
        wr(REG_CTRL, 32'h80);
        idle();
        for (int c = 0; c < 4; c++) begin
            rd(REG_CHAN0 + 6'(4 * c));
            chk(v, 32'h1234 + 32'h1111 * c, "channel data");
        end
        wr(REG_RUNCMD, 32'h0400);
        wr(REG_CTRL, 32'h84);
        idle();
        rd(REG_CTRL);
        chk(v[CB_MODE], 32'h0, "back to configure");
        cfg(1'b1, 14'h0030, 8'h00);
        rd(REG_CRD);
        chk(v, 32'h77, "run command applied");
        $display("run tests done");
        tally_and_finish();
    end
endmodule
